// ===== trace_resource_pause_control_bench.sv
// Self-checking bench for trpc_top with a behavioural core beside it.
// Assumes a 125 MHz clk_sys and sys_rst held for six cycles.
`default_nettype none
`include "trpc_regs.vh"
module trace_resource_pause_control_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0, sys_rst = 1'b1, buf_overflow = 1'b0;
  logic lp_cmd = 1'b0, pr_cmd = 1'b0, blk_cmd = 1'b0, sync_cmd = 1'b0;
  logic low_power, prohibited_region, blk_valid, cmp_busy, sync_req;
  logic sel_one, blk_eval, sync_done;
  logic [3:0] busy_len = 4'h0, cnt_dec = 4'h0, cnt_load = 4'h0, seq_goto = 4'h0;
  logic [3:0] xout_req = 4'h0, sel_cnt_zero, sel_seq, ext_out;
  logic [7:0] res_in = 8'h00, sel_res, s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, rd;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  int bad_count = 0, total_checks = 0, n;
  always #4 clk_sys = ~clk_sys;
  trpc_top DUT (.clk_sys(clk_sys), .sys_rst(sys_rst), .low_power(low_power),
    .prohibited_region(prohibited_region), .buf_overflow(buf_overflow), .res_in(res_in),
    .cnt_dec(cnt_dec), .cnt_load(cnt_load), .seq_goto(seq_goto), .xout_req(xout_req),
    .blk_valid(blk_valid), .cmp_busy(cmp_busy), .sync_req(sync_req), .sel_res(sel_res),
    .sel_cnt_zero(sel_cnt_zero), .sel_seq(sel_seq), .sel_one(sel_one), .ext_out(ext_out),
    .blk_eval(blk_eval), .sync_done(sync_done), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready));
  trpc_core_model u_core (.clk_sys(clk_sys), .lp_cmd(lp_cmd), .pr_cmd(pr_cmd),
    .blk_cmd(blk_cmd), .sync_cmd(sync_cmd), .busy_len(busy_len), .low_power(low_power),
    .prohibited_region(prohibited_region), .blk_valid(blk_valid), .sync_req(sync_req),
    .cmp_busy(cmp_busy));
  // ==========================================================================
  // Shared tasks
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_sys);
  endtask
  // Address and data are released each on its own ready
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge clk_sys);
    s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_awready) begin ad = 1'b1; s_axi_awvalid <= 1'b0; end
      if (s_axi_wready) begin wd = 1'b1; s_axi_wvalid <= 1'b0; end
    end while (!(ad && wd));
    do @(posedge clk_sys); while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk_sys);
    s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
    do @(posedge clk_sys); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk_sys); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // ==========================================================================
  // Scenarios
  task automatic t_reset;
    axr(`TRPC_CTRL_OFF, rd, resp); chk("ctrl", 32'h0000_0000, rd);
    axr(`TRPC_STAT_OFF, rd, resp); chk("stat", 32'h0000_0F14, rd & 32'hFFFF_FFF7);
    chk("sel_one", 1'b0, sel_one);
    axr(8'h0C, rd, resp); chk("rresp", `TRPC_RESP_SLVERR, resp); chk("rdata", 0, rd);
    axw(`TRPC_STAT_OFF, 32'h0000_0001, resp); chk("bresp", `TRPC_RESP_SLVERR, resp);
  endtask
  task automatic t_run;
    axw(`TRPC_CTRL_OFF, 32'h0000_0001, resp); chk("bresp", `TRPC_RESP_OKAY, resp);
    res_in <= 8'hA5; xout_req <= 4'h9; buf_overflow <= 1'b1;
    cyc(4); chk("sel_one", 1'b1, sel_one);
    chk("sel_res", 8'hA5, sel_res); chk("ext_out", 4'h9, ext_out);
    axr(`TRPC_STAT_OFF, rd, resp); chk("running", 3'h1, rd[2:0]);
    axr(`TRPC_XOUT_OFF, rd, resp); chk("xout reg", 32'h0000_0009, rd);
    chk("overflow run", 1'b1, sel_one);
  endtask
  task automatic t_pause;
    lp_cmd <= 1'b1; buf_overflow <= 1'b0;
    // Raw inputs drop just as Pausing starts; the held values must still show
    cyc(2); res_in <= 8'h00;
    cyc(2); chk("held", 8'hA5, sel_res); chk("ext_out", 4'h0, ext_out);
    cyc(4); chk("sel_res", 8'h00, sel_res); chk("ext_out", 4'h0, ext_out);
    res_in <= 8'hFF; cnt_load <= 4'hF; buf_overflow <= 1'b1;
    cyc(4); chk("paused res", 8'h00, sel_res); chk("paused cnt", 4'hF, sel_cnt_zero);
    axr(`TRPC_STAT_OFF, rd, resp); chk("no stable", 4'h4, rd[3:0]);
    axr(`TRPC_XOUT_OFF, rd, resp); chk("xout paused", 32'h0000_0000, rd);
    cnt_load <= 4'h0; chk("overflow paused", 1'b0, sel_one);
    lp_cmd <= 1'b0; pr_cmd <= 1'b1; buf_overflow <= 1'b0;
    cyc(5); chk("region", 1'b0, sel_one);
    pr_cmd <= 1'b0; cyc(5); chk("resume", 1'b1, sel_one);
  endtask
  task automatic t_counters;
    // Two counters leave zero, then one of them is brought back to zero
    cnt_load <= 4'h3; seq_goto <= 4'h4; @(posedge clk_sys);
    cnt_load <= 4'h0; seq_goto <= 4'h0; cnt_dec <= 4'h2; @(posedge clk_sys);
    cnt_dec <= 4'h0;
    cyc(3); chk("cnt", 4'hE, sel_cnt_zero); chk("seq", 4'h4, sel_seq);
    axw(`TRPC_CTRL_OFF, 32'h0000_0003, resp); cyc(6); chk("locked", 1'b0, sel_one);
    axr(`TRPC_STAT_OFF, rd, resp); chk("view", 32'h0000_0E4C, rd);
    chk("stable", 1'b1, rd[`TRPC_STAT_PMST]);
    axw(`TRPC_CTRL_OFF, 32'h0000_0001, resp); cyc(4); chk("unlock", 1'b1, sel_one);
  endtask
  task automatic t_blk_sync;
    blk_cmd <= 1'b1; @(posedge clk_sys); blk_cmd <= 1'b0; n = 0;
    repeat (6) begin @(posedge clk_sys); n += (blk_eval === 1'b1); end
    chk("evals", 1, n);
    for (int i = 1; i >= 0; i--) begin
      busy_len <= i ? 4'h6 : 4'h0; sync_cmd <= 1'b1; n = 0;
      do begin @(posedge clk_sys); n++; end while (sync_done !== 1'b1 && n < 40);
      chk("sync wait", i ? 1 : 0, n > 6); chk("sync late", 0, n > 12);
      sync_cmd <= 1'b0; cyc(3);
    end
    axw(`TRPC_CTRL_OFF, 32'h0000_0000, resp); cyc(6); chk("disable", 1'b0, sel_one);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk_sys);
    bad_count++;
    test_done();
  end
  initial begin
    cyc(6); sys_rst <= 1'b0; cyc(2);
    t_reset(); t_run(); t_pause(); t_counters(); t_blk_sync();
    test_done();
  end
endmodule // trace_resource_pause_control_bench
`default_nettype wire

// ===== trpc_core_model.sv
// Behavioural core: power, region, block and sync status lines.
// Assumes the bench commands it; outputs move just after clk_sys rises.
`default_nettype none
module trpc_core_model (
  input  wire logic       clk_sys,
  input  wire logic       lp_cmd,
  input  wire logic       pr_cmd,
  input  wire logic       blk_cmd,
  input  wire logic       sync_cmd,
  input  wire logic [3:0] busy_len,
  output logic            low_power = 1'b0,
  output logic            prohibited_region = 1'b0,
  output logic            blk_valid = 1'b0,
  output logic            sync_req = 1'b0,
  output logic            cmp_busy = 1'b0
);
  logic [3:0] busy_r = 4'h0;  // Comparator work still outstanding
  // Busy length lets one sync answer promptly and another slowly
  always @(posedge clk_sys) begin
    low_power         <= lp_cmd;
    prohibited_region <= pr_cmd;
    blk_valid         <= blk_cmd;
    if (sync_cmd && !sync_req) begin
      sync_req <= 1'b1;
      busy_r   <= busy_len;
      cmp_busy <= (busy_len != 4'h0);
    end else if (busy_r != 4'h0) begin
      busy_r   <= busy_r - 4'h1;
      cmp_busy <= (busy_r > 4'h1);
    end else if (!sync_cmd) begin
      sync_req <= 1'b0;
    end
  end
endmodule // trpc_core_model
`default_nettype wire

// ===== trpc_regs.vh
// Constants for the trace resource pause control block.
// Assumes a 32-bit AXI4-Lite register bus and a single system clock.
`ifndef TRPC_REGS_VH
`define TRPC_REGS_VH
// ==========================================================================
// Register byte offsets
`define TRPC_CTRL_OFF    8'h00
`define TRPC_STAT_OFF    8'h04
`define TRPC_XOUT_OFF    8'h08
// ==========================================================================
// Field positions
`define TRPC_CTRL_EN     0
`define TRPC_CTRL_LOCK   1
`define TRPC_STAT_RUN    0
`define TRPC_STAT_PSNG   1
`define TRPC_STAT_PSD    2
`define TRPC_STAT_PMST   3
`define TRPC_STAT_SEQ    4
`define TRPC_STAT_CZ     8
// ==========================================================================
// Reset values and answers
`define TRPC_CTRL_RST    2'h0
`define TRPC_RESP_OKAY   2'h0
`define TRPC_RESP_SLVERR 2'h2
`define TRPC_ZERO32      32'h0000_0000
`endif

// ===== trpc_top.v
// Resource run/pause control for a trace unit filtering block.
// Assumes the core drives its status inputs synchronous to clk_sys and
// software reaches control and status over AXI4-Lite.
// Summary of operation
// - Exactly one of Running, Pausing, Paused
// - Paused: all static except external input selectors
// - Disabled when enable clear or lock set
// - Running to Pausing on disable, lowpower, prohibited
// - Pausing always reaches Paused in bounded time
// - Paused to Running only when all clear
// - Buffer overflow never affects resource state
// - Pausing forces non-counter, non-sequencer inputs low
// - Held pre-force values still propagate through selectors
// - Then counters, sequencer propagate once more; Paused
// - Looped counter activations may drop at end
// - Register view matches counter, sequencer events
// - Paused and enabled: keep in-transit events; here counters and sequencer ignore events once Paused, enabled or not
// - Paused may delay in-transit event observation
// - Paused: resources hold, external outputs low
// - Stable flag set only when disabled and Paused
// - Stable flag high: everything stays quiescent
// - Sync completes after comparators finish older work
// - Precise resources evaluated once per block; here only blocks arriving while Running are evaluated
// - Precise resources kept in program order
// - Selector one true while Running
//
// Added by the designer: the AXI4-Lite register port and the register addresses.
`default_nettype none
`include "trpc_regs.vh"

module trpc_top #(
  parameter NRES  = 8,   // Non-counter resource inputs
  parameter NCNT  = 4,   // Counters
  parameter NSEQ  = 4,   // Sequencer states
  parameter NXOUT = 4    // External outputs
) (
  input  wire              clk_sys,
  input  wire              sys_rst,
  // Core side status
  input  wire              low_power,
  input  wire              prohibited_region,
  input  wire              buf_overflow,
  // Resource producers
  input  wire [NRES-1:0]   res_in,
  input  wire [NCNT-1:0]   cnt_dec,
  input  wire [NCNT-1:0]   cnt_load,
  input  wire [NSEQ-1:0]   seq_goto,
  input  wire [NXOUT-1:0]  xout_req,
  // Instruction block flow
  input  wire              blk_valid,
  input  wire              cmp_busy,
  input  wire              sync_req,
  // Results
  output reg  [NRES-1:0]   sel_res,
  output reg  [NCNT-1:0]   sel_cnt_zero,
  output reg  [NSEQ-1:0]   sel_seq,
  output reg               sel_one,
  output reg  [NXOUT-1:0]  ext_out,
  output reg               blk_eval,
  output reg               sync_done,
  // AXI4-Lite slave
  input  wire [7:0]        s_axi_awaddr,
  input  wire              s_axi_awvalid,
  output reg               s_axi_awready,
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output reg               s_axi_wready,
  output reg  [1:0]        s_axi_bresp,
  output reg               s_axi_bvalid,
  input  wire              s_axi_bready,
  input  wire [7:0]        s_axi_araddr,
  input  wire              s_axi_arvalid,
  output reg               s_axi_arready,
  output reg  [31:0]       s_axi_rdata,
  output reg  [1:0]        s_axi_rresp,
  output reg               s_axi_rvalid,
  input  wire              s_axi_rready
);

  // ========================================================================
  // States, one-hot
  localparam [2:0] ST_RUN  = 3'h1;
  localparam [2:0] ST_PSNG = 3'h2;
  localparam [2:0] ST_PSD  = 3'h4;
  // Pausing steps, one-hot: held values, then counter/sequencer pass
  localparam [1:0] PS_HOLD = 2'h1;
  localparam [1:0] PS_LOOP = 2'h2;

  reg [2:0]      state_r;       // Resource operating state
  reg [2:0]      state_nxt;
  reg [1:0]      pstep_r;       // Pausing step
  reg [1:0]      pstep_nxt;
  reg [1:0]      ctrl_r;        // Enable and lock bits
  reg [NRES-1:0] res_hold_r;    // Inputs sampled before forcing low
  reg [NCNT-1:0] cnt_nz_r;      // Counter non-zero state
  reg [NSEQ-1:0] seq_r;         // Sequencer state, one-hot
  reg            pm_stable_r;   // Programmers model stable
  reg            wr_aw_r;       // Write address captured
  reg            wr_w_r;        // Write data captured
  reg [7:0]      awaddr_r;
  reg [31:0]     wdata_r;
  reg [3:0]      wstrb_r;

  // ========================================================================
  // Disable and pause conditions
  wire trace_program_enable = ctrl_r[`TRPC_CTRL_EN];
  wire os_lock_set          = ctrl_r[`TRPC_CTRL_LOCK];
  wire unit_disabled = ~trace_program_enable | os_lock_set;
  // Overflow deliberately takes no part here
  wire pause_cond = unit_disabled | low_power | prohibited_region;
  wire active     = state_r == ST_RUN;
  // Counters and sequencer keep going in Pausing, frozen once Paused
  wire cs_live    = (state_r != ST_PSD) & ~pm_stable_r;

  // Reads as unused on purpose; overflow is watched by other logic
  wire unused_ok = buf_overflow;

  // ========================================================================
  // Next state
  always @* begin
    state_nxt = state_r;
    pstep_nxt = pstep_r;
    case (state_r)
      ST_RUN: begin
        if (pause_cond) begin
          state_nxt = ST_PSNG;
          pstep_nxt = PS_HOLD;
        end
      end
      ST_PSNG: begin
        // Two fixed steps bound the time in Pausing
        case (pstep_r)
          PS_HOLD: pstep_nxt = PS_LOOP;
          PS_LOOP: begin
            state_nxt = ST_PSD;
            pstep_nxt = PS_HOLD;
          end
          default: state_nxt = ST_PSD;
        endcase
      end
      ST_PSD: begin
        if (!pause_cond) state_nxt = ST_RUN;
      end
      default: state_nxt = ST_PSD;
    endcase
  end

  // ========================================================================
  // State registers
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      state_r <= ST_PSD;
      pstep_r <= PS_HOLD;
    end else begin
      state_r <= state_nxt;
      pstep_r <= pstep_nxt;
    end
  end

  // ========================================================================
  // Input capture: held only while Running, so Pausing still sees the
  // last live values once the raw inputs are forced low
  always @(posedge clk_sys) begin
    if (sys_rst) res_hold_r <= {NRES{1'b0}};
    else if (active) res_hold_r <= res_in;
  end

  // ========================================================================
  // Counters and sequencer, reduced to what the selectors observe
  genvar gi;
  generate
    for (gi = 0; gi < NCNT; gi = gi + 1) begin : g_cnt
      always @(posedge clk_sys) begin
        if (sys_rst) cnt_nz_r[gi] <= 1'b0;
        else if (cs_live) begin
          if (cnt_load[gi]) cnt_nz_r[gi] <= 1'b1;
          else if (cnt_dec[gi]) cnt_nz_r[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  always @(posedge clk_sys) begin
    if (sys_rst) seq_r <= {{(NSEQ-1){1'b0}}, 1'b1};
    else if (cs_live && (seq_goto != {NSEQ{1'b0}})) seq_r <= seq_goto;
  end

  // ========================================================================
  // Selector outputs; a late loop activation at the end of Pausing may
  // miss this pass, which is accepted
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      sel_res      <= {NRES{1'b0}};
      sel_cnt_zero <= {NCNT{1'b0}};
      sel_seq      <= {NSEQ{1'b0}};
      sel_one      <= 1'b0;
    end else begin
      case (state_r)
        ST_RUN:  sel_res <= res_in;
        ST_PSNG: sel_res <= (pstep_r == PS_HOLD) ? res_hold_r
                                                 : {NRES{1'b0}};
        default: sel_res <= sel_res;
      endcase
      // Same registers feed status, so both views agree
      sel_cnt_zero <= ~cnt_nz_r;
      sel_seq      <= seq_r;
      sel_one      <= state_nxt == ST_RUN;
    end
  end

  // ========================================================================
  // External outputs are low whenever not Running
  always @(posedge clk_sys) begin
    if (sys_rst) ext_out <= {NXOUT{1'b0}};
    else ext_out <= (state_nxt == ST_RUN) ? xout_req : {NXOUT{1'b0}};
  end

  // ========================================================================
  // Stable flag: never ahead of disabled-and-Paused
  always @(posedge clk_sys) begin
    if (sys_rst) pm_stable_r <= 1'b0;
    else pm_stable_r <= unit_disabled & (state_r == ST_PSD);
  end

  // ========================================================================
  // Precise path: one evaluation per block arriving while Running, in arrival order; a sync
  // completes only once the comparators have drained older work
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      blk_eval  <= 1'b0;
      sync_done <= 1'b0;
    end else begin
      blk_eval  <= blk_valid & active;
      sync_done <= sync_req & ~cmp_busy;
    end
  end

  // ========================================================================
  // AXI4-Lite write side; address and data taken in either order
  wire wr_go = wr_aw_r & wr_w_r & ~s_axi_bvalid;
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      wr_aw_r       <= 1'b0;
      wr_w_r        <= 1'b0;
      awaddr_r      <= 8'h00;
      wdata_r       <= `TRPC_ZERO32;
      wstrb_r       <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `TRPC_RESP_OKAY;
      ctrl_r        <= `TRPC_CTRL_RST;
    end else begin
      s_axi_awready <= ~wr_aw_r & ~s_axi_awready & ~s_axi_bvalid;
      s_axi_wready  <= ~wr_w_r & ~s_axi_wready & ~s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        wr_aw_r  <= 1'b1;
        awaddr_r <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wr_w_r  <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        wr_aw_r      <= 1'b0;
        wr_w_r       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (awaddr_r == `TRPC_CTRL_OFF) begin
          s_axi_bresp <= `TRPC_RESP_OKAY;
          if (wstrb_r[0]) ctrl_r <= wdata_r[1:0];
        end else begin
          s_axi_bresp <= `TRPC_RESP_SLVERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ========================================================================
  // AXI4-Lite read side
  reg [31:0] stat_word;
  always @* begin
    stat_word = `TRPC_ZERO32;
    stat_word[`TRPC_STAT_RUN]  = state_r == ST_RUN;
    stat_word[`TRPC_STAT_PSNG] = state_r == ST_PSNG;
    stat_word[`TRPC_STAT_PSD]  = state_r == ST_PSD;
    stat_word[`TRPC_STAT_PMST] = pm_stable_r;
    stat_word[`TRPC_STAT_SEQ +: NSEQ] = seq_r;
    stat_word[`TRPC_STAT_CZ +: NCNT]  = ~cnt_nz_r;
  end

  always @(posedge clk_sys) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= `TRPC_ZERO32;
      s_axi_rresp   <= `TRPC_RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= `TRPC_RESP_OKAY;
        case (s_axi_araddr)
          `TRPC_CTRL_OFF: s_axi_rdata <= {30'h0000_0000, ctrl_r};
          `TRPC_STAT_OFF: s_axi_rdata <= stat_word;
          `TRPC_XOUT_OFF: s_axi_rdata <= {{(32-NXOUT){1'b0}}, ext_out};
          default: begin
            s_axi_rdata <= `TRPC_ZERO32;
            s_axi_rresp <= `TRPC_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // trpc_top
`default_nettype wire

// ===== trpc_top_props.sv
// Assertions on the ports of the resource pause controller.
// Assumes one clock, clk_sys, and a synchronous active-high sys_rst.
`default_nettype none
`include "trpc_regs.vh"
module trpc_top_props #(
  parameter NRES  = 8,
  parameter NCNT  = 4,
  parameter NSEQ  = 4,
  parameter NXOUT = 4
) (
  input wire logic             clk_sys,
  input wire logic             sys_rst,
  input wire logic             low_power,
  input wire logic             prohibited_region,
  input wire logic [NRES-1:0]  sel_res,
  input wire logic [NCNT-1:0]  sel_cnt_zero,
  input wire logic [NSEQ-1:0]  sel_seq,
  input wire logic             sel_one,
  input wire logic [NXOUT-1:0] ext_out,
  input wire logic             blk_valid,
  input wire logic             blk_eval,
  input wire logic             sync_req,
  input wire logic             cmp_busy,
  input wire logic             sync_done,
  input wire logic [7:0]       s_axi_araddr,
  input wire logic             s_axi_arvalid,
  input wire logic             s_axi_arready,
  input wire logic             s_axi_rvalid,
  input wire logic [31:0]      s_axi_rdata
);
  // ==========================================================================
  // Read address kept so a status answer can be recognised
  logic [7:0] rd_addr_r;
  always_ff @(posedge clk_sys) begin
    if (s_axi_arvalid && s_axi_arready) rd_addr_r <= s_axi_araddr;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // Slack of one cycle because the selector one output is registered
  property p_run_exit; sel_one && (low_power || prohibited_region) |-> ##[1:2] !sel_one; endproperty
  a_run_exit: assert property (p_run_exit) else $error("run did not stop");
  property p_drain; $fell(sel_one) |-> ##[1:3] (sel_res == '0); endproperty
  a_drain: assert property (p_drain) else $error("selectors not drained");
  property p_xout_low; (low_power || prohibited_region)[*3] |-> ext_out == '0; endproperty
  a_xout_low: assert property (p_xout_low) else $error("external out high");
  property p_hold; low_power[*7] |-> $stable(sel_cnt_zero) && $stable(sel_seq) && sel_res == '0;
  endproperty
  a_hold: assert property (p_hold) else $error("paused state moved");
  property p_stay_paused; (low_power || prohibited_region)[*4] |-> !sel_one; endproperty
  a_stay_paused: assert property (p_stay_paused) else $error("ran while a cause held");
  property p_pm_stable;
    s_axi_rvalid && rd_addr_r == `TRPC_STAT_OFF && s_axi_rdata[3] |-> s_axi_rdata[2:0] == 3'h4;
  endproperty
  a_pm_stable: assert property (p_pm_stable) else $error("stable flag early");
  property p_one_state; s_axi_rvalid && rd_addr_r == `TRPC_STAT_OFF |-> $onehot(s_axi_rdata[2:0]);
  endproperty
  a_one_state: assert property (p_one_state) else $error("state not one-hot");
  property p_blk; blk_eval |-> $past(blk_valid); endproperty
  a_blk: assert property (p_blk) else $error("evaluation without block");
  property p_sync; sync_done |-> $past(sync_req) && !$past(cmp_busy); endproperty
  a_sync: assert property (p_sync) else $error("sync done while busy");
  property p_sync_go; sync_req && !cmp_busy |=> sync_done; endproperty
  a_sync_go: assert property (p_sync_go) else $error("sync not completed");
endmodule // trpc_top_props
bind trpc_top trpc_top_props #(.NRES(NRES), .NCNT(NCNT), .NSEQ(NSEQ), .NXOUT(NXOUT)) u_props (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .low_power(low_power),
  .prohibited_region(prohibited_region), .sel_res(sel_res), .sel_cnt_zero(sel_cnt_zero),
  .sel_seq(sel_seq), .sel_one(sel_one), .ext_out(ext_out), .blk_valid(blk_valid),
  .blk_eval(blk_eval), .sync_req(sync_req), .cmp_busy(cmp_busy), .sync_done(sync_done),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rdata(s_axi_rdata));
`default_nettype wire
